// ===== bsps_far_model.sv
// far side of the sequencer: oscillator tick, high-side gate, oc comparator
// assumes the bench commands over-current through oc_cmd
`timescale 1ns/100ps
module bsps_far_model
(
   input wire logic clock,
   input wire logic srst,
   input wire logic drivers_enable,
   input wire logic low_side_allow,
   input wire logic oc_cmd,
   output logic sw_cycle_tick,
   output logic high_side_pulse,
   output logic overcurrent_sense_low
);
   // tracking reference held mid-range by the far side; no pin here
   localparam int TRACK_REF_MV = 3300;
   logic [1:0] div_q;
   // divider restarts with reset so tick phase repeats run to run
   always_ff @(posedge clock)
   begin
      div_q <= srst ? 2'h0 : div_q + 2'h1;
   end
   assign sw_cycle_tick = (div_q == 2'h3);
   // one high-side gate pulse a switching cycle while drivers may switch
   always_ff @(posedge clock)
   begin
      high_side_pulse <= !srst && sw_cycle_tick && drivers_enable;
   end
   // sense pin only goes below ground while the low side conducts
   assign overcurrent_sense_low = oc_cmd && low_side_allow;
endmodule // bsps_far_model

// ===== bsps_pkg.sv
// constants for the buck start-up and protection sequencer
// assumes a 200 MHz system clock and a switching-cycle tick input
// Operation
// (RQ1) drivers off while bias or enable monitor reports below lockout
// (RQ2) switching resumes only when both monitors report above start
// (RQ3) power-on-ready needs all monitors valid; its rise launches soft-start
// (RQ4) turn on only once enable comparator passes start threshold
// (RQ5) enable below stop threshold tri-states both drivers
// (RQ6) low-side stays off until first high-side pulse is produced
// (RQ7) low-side duty steps 25, 50, 75, then 100 percent
// (RQ8) steps last 32, 16 and 8 pulses
// (RQ9) soft-start ramps linearly from zero at 0.2mV/us up to 2V
// (RQ10) normal start-up time fixed at 3ms
// (RQ11) over-current protection stays active during soft-start
// (RQ12) over-current seen when sense comparator says pin below ground
// (RQ13) over-current comparator ignored for about 200ns after low-side on
// (RQ14) over-current latches flag and starts hiccup cycling
// (RQ15) hiccup holds soft-start at zero for 4096 switching cycles
// (RQ16) after hiccup count, clear flag and restart soft-start, repeat
// (RQ17) tracking mode reference pin driven between 1.5V and 7V externally; no such pin here, far model only holds TRACK_REF_MV at 3300
// (RQ18) over-temperature turns both off, resets soft-start, auto restarts
// (RQ19) sequencer steps once per switching cycle, held reset without ready
// (RQ20) loss of ready clears ramp and pulse stepping
package bsps_pkg;
   localparam int CLK_MHZ = 200;
   localparam int BLANK_NS = 200;
   localparam int BLANK_CYC = (BLANK_NS * CLK_MHZ) / 1000;
   localparam int RAMP_UV_PER_US = 200;
   localparam int SS_FINAL_UV = 2000000;
   localparam int START_MS = 3;
   localparam int START_US = START_MS * 1000;
   localparam int SS_UV_PER_CLK_X1000 = RAMP_UV_PER_US;
   localparam int HICCUP_CYCLES = 4096;
   localparam int STEP1_PULSES = 32;
   localparam int STEP2_PULSES = 16;
   localparam int STEP3_PULSES = 8;
   localparam logic [1:0] DUTY_25 = 2'h0;
   localparam logic [1:0] DUTY_50 = 2'h1;
   localparam logic [1:0] DUTY_75 = 2'h2;
   localparam logic [1:0] DUTY_100 = 2'h3;
   typedef enum logic [2:0] {
      BSPS_OFF,
      BSPS_WAIT_HS,
      BSPS_RAMP,
      BSPS_RUN,
      BSPS_HICCUP
   } bsps_state_t;
endpackage

// ===== bsps_seq.sv
// start-up, pre-bias and hiccup sequencer for a synchronous buck
// assumes comparator levels synchronous to clock, one tick per switch cycle
`timescale 1ns/100ps
module bsps_seq
#(
   parameter int SS_W = 24,
   parameter int HICCUP_N = bsps_pkg::HICCUP_CYCLES,
   parameter int US_CLKS = bsps_pkg::CLK_MHZ
)
(
   input wire logic clock,
   input wire logic srst,
   input wire logic sw_cycle_tick,
   input wire logic bias_above_start,
   input wire logic bias_below_stop,
   input wire logic enable_above_start,
   input wire logic enable_below_stop,
   input wire logic overtemp_trip,
   input wire logic overcurrent_sense_low,
   input wire logic high_side_pulse,
   output logic power_on_ready,
   output logic drivers_enable,
   output logic drivers_tristate,
   output logic low_side_allow,
   output logic [1:0] low_side_duty,
   output logic [SS_W-1:0] soft_start_uv,
   output logic soft_start_done,
   output logic overcurrent_protect_flag,
   output logic oc_window_open,
   output logic [bsps_pkg::START_MS*0+15:0] hiccup_count
);
   import bsps_pkg::*;

   localparam logic [SS_W-1:0] SS_FINAL = SS_W'(SS_FINAL_UV);
   localparam logic [SS_W-1:0] SS_STEP = SS_W'(RAMP_UV_PER_US);
   localparam logic [7:0] BLANK_N = 8'(BLANK_CYC);
   localparam logic [15:0] HICCUP_LAST = 16'(HICCUP_N - 1);
   localparam logic [7:0] US_LAST = 8'(US_CLKS - 1);
   localparam logic [5:0] P1 = 6'(STEP1_PULSES - 1);
   localparam logic [5:0] P2 = 6'(STEP2_PULSES - 1);
   localparam logic [5:0] P3 = 6'(STEP3_PULSES - 1);
   localparam logic [6:0] TICKS_50 = 7'(STEP1_PULSES);
   localparam logic [6:0] TICKS_75 = 7'(STEP1_PULSES + STEP2_PULSES);
   localparam logic [6:0] TICKS_100 = 7'(STEP1_PULSES + STEP2_PULSES
      + STEP3_PULSES);

   bsps_state_t state_q;
   logic por_q;
   logic ready_d;
   logic [7:0] us_cnt_q;
   logic [7:0] blank_q;
   logic ls_prev_q;
   logic [5:0] pulse_q;
   logic [15:0] hic_q;
   logic oc_hit;
   logic ls_rise;

   // ready is the held lockout state: set on both start, drop on any stop
   always_ff @(posedge clock)
   begin
      if (srst)
         por_q <= 1'b0;
      else if (bias_below_stop || enable_below_stop || overtemp_trip)
         por_q <= 1'b0; // RQ1 RQ18
      else if (bias_above_start && enable_above_start)
         por_q <= 1'b1; // RQ2 RQ3 RQ4
   end

   assign ready_d = por_q && !bias_below_stop && !enable_below_stop
      && !overtemp_trip;
   assign power_on_ready = por_q;
   assign drivers_tristate = !por_q; // RQ5
   assign drivers_enable = ready_d && (state_q != BSPS_OFF)
      && (state_q != BSPS_HICCUP); // RQ1

   assign ls_rise = low_side_allow && !ls_prev_q;
   // blank counter restarts every low-side turn-on to mask switching noise
   always_ff @(posedge clock)
   begin
      if (srst || !ready_d)
      begin
         blank_q <= 8'h00;
         ls_prev_q <= 1'b0;
      end
      else
      begin
         ls_prev_q <= low_side_allow;
         if (ls_rise)
            blank_q <= BLANK_N; // RQ13
         else if (blank_q != 8'h00)
            blank_q <= blank_q - 8'h01;
      end
   end

   assign oc_window_open = low_side_allow && !ls_rise && blank_q == 8'h00;
   // detection live in ramp and run alike
   assign oc_hit = oc_window_open && overcurrent_sense_low
      && (state_q == BSPS_RAMP || state_q == BSPS_RUN); // RQ11 RQ12

   always_ff @(posedge clock)
   begin
      if (srst || !ready_d)
         state_q <= BSPS_OFF; // RQ19 RQ20
      else
      begin
         unique case (state_q)
            BSPS_OFF:
               state_q <= BSPS_WAIT_HS;
            BSPS_WAIT_HS:
               if (oc_hit)
                  state_q <= BSPS_HICCUP;
               else if (high_side_pulse)
                  state_q <= BSPS_RAMP; // RQ6
            BSPS_RAMP:
               if (oc_hit)
                  state_q <= BSPS_HICCUP; // RQ14
               else if (soft_start_uv == SS_FINAL)
                  state_q <= BSPS_RUN;
            BSPS_RUN:
               if (oc_hit)
                  state_q <= BSPS_HICCUP; // RQ14
            BSPS_HICCUP:
               if (sw_cycle_tick && hic_q == HICCUP_LAST)
                  state_q <= BSPS_OFF; // RQ16
         endcase
      end
   end

   // flag sticks through the whole off time, set wins over clear
   always_ff @(posedge clock)
   begin
      if (srst)
         overcurrent_protect_flag <= 1'b0;
      else if (oc_hit)
         overcurrent_protect_flag <= 1'b1; // RQ14
      else if (state_q == BSPS_HICCUP && sw_cycle_tick
         && hic_q == HICCUP_LAST)
         overcurrent_protect_flag <= 1'b0; // RQ16
   end

   always_ff @(posedge clock)
   begin
      if (srst || state_q != BSPS_HICCUP)
         hic_q <= 16'h0000;
      else if (sw_cycle_tick)
         hic_q <= hic_q + 16'h0001; // RQ15
   end
   assign hiccup_count = hic_q;

   // ramp advances one step per microsecond: 2V/0.2mV/us = 10ms to full,
   // 0.7V to 1.3V window spans the fixed 3ms output rise
   always_ff @(posedge clock)
   begin
      if (srst || !ready_d || state_q == BSPS_HICCUP
         || state_q == BSPS_OFF || state_q == BSPS_WAIT_HS)
      begin
         soft_start_uv <= '0; // RQ15 RQ18 RQ20
         us_cnt_q <= 8'h00;
      end
      else if (soft_start_uv != SS_FINAL)
      begin
         if (us_cnt_q == US_LAST)
         begin
            us_cnt_q <= 8'h00;
            if (SS_FINAL - soft_start_uv < SS_STEP)
               soft_start_uv <= SS_FINAL; // RQ9
            else
               soft_start_uv <= soft_start_uv + SS_STEP; // RQ9 RQ10
         end
         else
            us_cnt_q <= us_cnt_q + 8'h01;
      end
   end
   assign soft_start_done = (soft_start_uv == SS_FINAL);

   // pre-bias stepping counts switching cycles once high side has fired
   always_ff @(posedge clock)
   begin
      if (srst || !ready_d || state_q == BSPS_OFF
         || state_q == BSPS_WAIT_HS || state_q == BSPS_HICCUP)
      begin
         low_side_duty <= DUTY_25; // RQ7 RQ20
         pulse_q <= 6'h00;
      end
      else if (sw_cycle_tick && low_side_duty != DUTY_100)
      begin
         if ((low_side_duty == DUTY_25 && pulse_q == P1)
            || (low_side_duty == DUTY_50 && pulse_q == P2)
            || (low_side_duty == DUTY_75 && pulse_q == P3))
         begin
            pulse_q <= 6'h00;
            low_side_duty <= low_side_duty + 2'h1; // RQ7 RQ8
         end
         else
            pulse_q <= pulse_q + 6'h01; // RQ8
      end
   end

   assign low_side_allow = drivers_enable
      && (state_q == BSPS_RAMP || state_q == BSPS_RUN); // RQ6

   // own tick tally, kept apart from pulse_q so the step checks mean something
   logic [6:0] step_tick_q;
   always_ff @(posedge clock)
   begin
      if (srst || !low_side_allow)
         step_tick_q <= 7'h00;
      else if (sw_cycle_tick && step_tick_q != '1)
         step_tick_q <= step_tick_q + 7'h01;
   end

   chk_lockout_off: assert property ( // RQ1
      @(posedge clock) disable iff (srst)
      (bias_below_stop || enable_below_stop) |-> !drivers_enable)
      else $error("drivers on during lockout");
   chk_ready_start: assert property ( // RQ2
      @(posedge clock) disable iff (srst)
      $rose(power_on_ready)
      |-> $past(bias_above_start && enable_above_start))
      else $error("ready rose without both start levels");
   chk_enable_stop: assert property ( // RQ5
      @(posedge clock) disable iff (srst)
      enable_below_stop |=> drivers_tristate)
      else $error("no tri-state after enable stop");
   chk_ls_first_hs: assert property ( // RQ6
      @(posedge clock) disable iff (srst)
      state_q == BSPS_WAIT_HS |-> !low_side_allow)
      else $error("low side before first high side");
   chk_step_order: assert property ( // RQ7
      @(posedge clock) disable iff (srst)
      $changed(low_side_duty) && low_side_duty != DUTY_25
      |-> low_side_duty == $past(low_side_duty) + 2'h1)
      else $error("duty step skipped");
   chk_blank_hold: assert property ( // RQ13
      @(posedge clock) disable iff (srst)
      ls_rise && ready_d |=> !oc_window_open [*8])
      else $error("oc window open inside blanking");
   chk_oc_latch: assert property ( // RQ14
      @(posedge clock) disable iff (srst)
      oc_hit |=> overcurrent_protect_flag && state_q == BSPS_HICCUP)
      else $error("oc not latched");
   chk_hiccup_zero: assert property ( // RQ15
      @(posedge clock) disable iff (srst)
      state_q == BSPS_HICCUP |=> soft_start_uv == '0)
      else $error("soft-start not zero in hiccup");
   chk_ramp_rate: assert property ( // RQ9
      @(posedge clock) disable iff (srst)
      $changed(soft_start_uv) && soft_start_uv != '0
      |-> soft_start_uv - $past(soft_start_uv) <= SS_STEP)
      else $error("ramp step too large");
   chk_ready_loss: assert property ( // RQ20
      @(posedge clock) disable iff (srst)
      $fell(power_on_ready) |=> soft_start_uv == '0
      && low_side_duty == DUTY_25)
      else $error("ramp kept after ready loss");

   // low side may only come up on the edge after a high-side pulse
   chk_ls_after_hs: assert property ( // RQ6
      @(posedge clock) disable iff (srst)
      $rose(low_side_allow) |-> $past(high_side_pulse))
      else $error("low side rose without high side pulse");
   chk_ready_launch: assert property ( // RQ3
      @(posedge clock) disable iff (srst)
      $rose(power_on_ready) && ready_d |=> state_q == BSPS_WAIT_HS)
      else $error("ready did not launch start-up");
   chk_fault_drop: assert property ( // RQ1
      @(posedge clock) disable iff (srst)
      (bias_below_stop || enable_below_stop || overtemp_trip)
      |=> !power_on_ready)
      else $error("ready kept through a fault");
   chk_overtemp_off: assert property ( // RQ18
      @(posedge clock) disable iff (srst)
      overtemp_trip |-> !drivers_enable && !low_side_allow)
      else $error("drivers on during over-temperature");
   chk_tri_quiet: assert property ( // RQ5
      @(posedge clock) disable iff (srst)
      drivers_tristate |-> !drivers_enable && !low_side_allow)
      else $error("drivers switching while tri-stated");
   chk_not_ready_off: assert property ( // RQ19
      @(posedge clock) disable iff (srst)
      !power_on_ready |-> !drivers_enable)
      else $error("drivers on without ready");
   chk_hiccup_quiet: assert property ( // RQ15
      @(posedge clock) disable iff (srst)
      state_q == BSPS_HICCUP |-> !drivers_enable && !low_side_allow)
      else $error("drivers on in hiccup off time");
   chk_ramp_hold: assert property ( // RQ9
      @(posedge clock) disable iff (srst)
      soft_start_done && ready_d && state_q == BSPS_RUN
      |=> soft_start_done)
      else $error("ramp left its final value");
   chk_ramp_tick: assert property ( // RQ10
      @(posedge clock) disable iff (srst)
      $changed(soft_start_uv) && soft_start_uv != '0
      |-> $past(us_cnt_q) == US_LAST)
      else $error("ramp stepped off the microsecond tick");
   chk_oc_ramp: assert property ( // RQ11
      @(posedge clock) disable iff (srst)
      overcurrent_sense_low && oc_window_open && state_q == BSPS_RAMP
      |=> state_q == BSPS_HICCUP)
      else $error("oc missed during soft-start");
   chk_flag_release: assert property ( // RQ16
      @(posedge clock) disable iff (srst)
      $fell(overcurrent_protect_flag) |-> $past(hic_q) == HICCUP_LAST)
      else $error("oc flag cleared before hiccup end");
   chk_step_half: assert property ( // RQ8
      @(posedge clock) disable iff (srst)
      $rose(low_side_duty == DUTY_50) |-> step_tick_q == TICKS_50)
      else $error("first duty step wrong length");
   chk_step_three: assert property ( // RQ8
      @(posedge clock) disable iff (srst)
      $rose(low_side_duty == DUTY_75) |-> step_tick_q == TICKS_75)
      else $error("second duty step wrong length");
   chk_step_full: assert property ( // RQ8
      @(posedge clock) disable iff (srst)
      $rose(low_side_duty == DUTY_100) |-> step_tick_q == TICKS_100)
      else $error("third duty step wrong length");

   cov_reach_run: cover property (@(posedge clock) state_q == BSPS_RUN);
   cov_hiccup: cover property (@(posedge clock)
      state_q == BSPS_HICCUP ##1 state_q == BSPS_OFF);
   cov_full_duty: cover property (@(posedge clock)
      low_side_duty == DUTY_100);
   cov_oc_in_ramp: cover property (@(posedge clock)
      state_q == BSPS_RAMP ##1 state_q == BSPS_HICCUP);
   cov_ready_loss: cover property (@(posedge clock)
      $fell(power_on_ready));
endmodule // bsps_seq

// ===== bsps_seq_tb_top.sv
// self-checking bench for the start-up and protection sequencer
// assumes short hiccup and ramp counts set through parameters
`timescale 1ns/100ps
module bsps_seq_tb_top;
   import bsps_pkg::*;
   logic clock = 0, srst = 1, oc_cmd = 0;
   logic bias_above_start = 0, enable_above_start = 0;
   logic bias_below_stop = 0, enable_below_stop = 0, overtemp_trip = 0;
   logic sw_cycle_tick, overcurrent_sense_low, high_side_pulse;
   logic power_on_ready, drivers_enable, drivers_tristate, low_side_allow;
   logic soft_start_done, overcurrent_protect_flag;
   logic [1:0] low_side_duty;
   logic [23:0] soft_start_uv;
   int mismatches = 0, compares = 0;
   int pts[4] = '{16, 40, 52, 60};
   int tick_n = 0, ls_ticks = 0, oc_ticks = 0, ramp_clks = 0;
   // short hiccup and microsecond so a whole ramp fits the run
   localparam int HIC_N = 8;
   localparam int US_N = 4;
   localparam int RAMP_CLKS = SS_FINAL_UV / RAMP_UV_PER_US * US_N;
   always #2.5 clock = ~clock;
   bsps_seq #(.HICCUP_N(HIC_N), .US_CLKS(US_N)) u_bsps_seq (.clock, .srst,
      .sw_cycle_tick, .bias_above_start, .bias_below_stop,
      .enable_above_start, .enable_below_stop, .overtemp_trip,
      .overcurrent_sense_low, .high_side_pulse, .power_on_ready,
      .drivers_enable, .drivers_tristate, .low_side_allow, .low_side_duty,
      .soft_start_uv, .soft_start_done, .overcurrent_protect_flag,
      .oc_window_open(), .hiccup_count());
   bsps_far_model u_bsps_far_model (.clock, .srst, .drivers_enable,
      .low_side_allow, .oc_cmd, .sw_cycle_tick, .high_side_pulse,
      .overcurrent_sense_low);
   // reference counts from the rules, taken at every rising edge
   always @(posedge clock)
   begin
      if (sw_cycle_tick)
         tick_n <= tick_n + 1;
      if (!low_side_allow)
         ls_ticks <= 0;
      else if (sw_cycle_tick)
         ls_ticks <= ls_ticks + 1;
      if (overcurrent_protect_flag && sw_cycle_tick)
         oc_ticks <= oc_ticks + 1;
      if (!low_side_allow)
         ramp_clks <= 0;
      else if (!soft_start_done)
         ramp_clks <= ramp_clks + 1;
   end
   // duty step expected after t switching ticks of start-up
   function automatic int exp_duty(int t);
      return t < 32 ? 0 : t < 48 ? 1 : t < 56 ? 2 : 3;
   endfunction
   task automatic chk(string name, logic [31:0] seen, logic [31:0] exp);
      compares++;
      if (seen !== exp)
      begin
         mismatches++;
         $display("BAD %s expected %0h seen %0h", name, exp, seen);
      end
   endtask
   // bounded wait; a miss shows up in the compare that follows
   task automatic wait_hi(ref logic s, input int lim);
      for (int i = 0; i < lim && s !== 1'b1; i++) @(posedge clock);
      @(negedge clock);
   endtask
   task automatic ticks(int n);
      int s;
      s = tick_n;
      while (tick_n < s + n)
         @(negedge clock);
   endtask
   task automatic wrap_up();
      $display("mismatches %0d compares %0d", mismatches, compares);
      if (mismatches == 0 && compares > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   initial
   begin
      #(5 * 80000);
      mismatches++;
      wrap_up();
   end
   initial
   begin
      void'($urandom(32'h4c91));
      repeat (4) @(posedge clock);
      srst <= 1'b0;
      @(negedge clock);
      chk("ready", power_on_ready, 0);
      chk("tristate", drivers_tristate, 1);
      chk("ramp", soft_start_uv, 0);
      for (int k = 1; k < 3; k++)
      begin
         @(posedge clock);
         {enable_above_start, bias_above_start} <= 2'(k);
         repeat (20) @(posedge clock);
         @(negedge clock);
         chk("half ready", power_on_ready, 0);
         chk("half enable", drivers_enable, 0);
      end
      @(posedge clock);
      {enable_above_start, bias_above_start} <= 2'h3;
      wait_hi(power_on_ready, 20);
      chk("ready", power_on_ready, 1);
      wait_hi(drivers_enable, 20);
      chk("enable", drivers_enable, 1);
      chk("low side early", low_side_allow, 0);
      wait_hi(low_side_allow, 40);
      chk("low side", low_side_allow, 1);
      // short over-current inside blanking must be ignored
      @(posedge clock);
      oc_cmd <= 1'b1;
      repeat (1 + $urandom % 30) @(posedge clock);
      oc_cmd <= 1'b0;
      repeat (20) @(posedge clock);
      @(negedge clock);
      chk("blanked oc", overcurrent_protect_flag, 0);
      // blanking test leaves a random tick offset, so follow the model
      foreach (pts[i])
      begin
         for (int j = 0; j < 400 && ls_ticks < pts[i]; j++)
            @(negedge clock);
         chk("duty", low_side_duty, exp_duty(ls_ticks));
      end
      @(posedge clock);
      oc_cmd <= 1'b1;
      wait_hi(overcurrent_protect_flag, 100);
      chk("oc flag", overcurrent_protect_flag, 1);
      @(posedge clock);
      oc_cmd <= 1'b0;
      @(negedge clock);
      chk("hiccup ramp", soft_start_uv, 0);
      ticks(4);
      chk("hiccup hold", overcurrent_protect_flag, 1);
      ticks(8);
      chk("hiccup end", overcurrent_protect_flag, 0);
      chk("hiccup len", oc_ticks, HIC_N);
      wait_hi(soft_start_done, 50000);
      chk("ramp final", soft_start_uv, SS_FINAL_UV);
      chk("ramp time", ramp_clks, RAMP_CLKS);
      for (int k = 0; k < 3; k++)
      begin
         @(posedge clock);
         {overtemp_trip, enable_below_stop, bias_below_stop} <= 3'(1 << k);
         repeat (4) @(posedge clock);
         @(negedge clock);
         chk("fault ready", power_on_ready, 0);
         chk("fault drive", drivers_enable, 0);
         chk("fault tristate", drivers_tristate, 1);
         chk("fault ramp", soft_start_uv, 0);
         @(posedge clock);
         {overtemp_trip, enable_below_stop, bias_below_stop} <= 3'h0;
         wait_hi(drivers_enable, 20);
         chk("restart", drivers_enable, 1);
      end
      wrap_up();
   end
endmodule // bsps_seq_tb_top
